// file: i2cms_cfg.svh
// Purpose: Register map, field positions and reset values of the bus sequencer
// Assumes: 8-bit register port, word index addressing
// Notes:   Definitions only
`ifndef I2CMS_CFG_SVH
`define I2CMS_CFG_SVH

// Register indices
`define I2CMS_OFS_CTRL      3'h0
`define I2CMS_OFS_BUSCTL    3'h1
`define I2CMS_OFS_STATUS    3'h2
`define I2CMS_OFS_RATE      3'h3
`define I2CMS_OFS_TXBUF     3'h4

// Control register fields
`define I2CMS_CTRL_EN       0
`define I2CMS_CTRL_MODE_LO  1
`define I2CMS_CTRL_MODE_HI  3
`define I2CMS_CTRL_FW_SCL   4
`define I2CMS_CTRL_FW_SDA   5

// Mode select codes
`define I2CMS_MODE_HWMASTER 3'h0
`define I2CMS_MODE_FWMASTER 3'h1

// Bus control register fields
`define I2CMS_BC_START      0
`define I2CMS_BC_RSTART     1
`define I2CMS_BC_STOP       2
`define I2CMS_BC_ACKRES     6

// Status register fields, write one to clear except LOADED
`define I2CMS_ST_EVENT      0
`define I2CMS_ST_WRITE_COLLISION_FLAG       1
`define I2CMS_ST_BCOL       2
`define I2CMS_ST_SDET       3
`define I2CMS_ST_PDET       4
`define I2CMS_ST_LOADED     5

// Reset values and the last bit index
`define I2CMS_RST_CTRL      8'h00
`define I2CMS_RST_RATE      8'h04
`define I2CMS_LAST_BIT      4'h8

`endif

// file: i2cms_pkg.sv
// Purpose: Types shared by the bus sequencer
// Assumes: Nothing
// Notes:   Constants live in i2cms_cfg.svh
package i2cms_pkg;

	typedef enum logic [3:0] {
		I2CMS_IDLE,
		I2CMS_ST_WAIT,
		I2CMS_ST_HOLD,
		I2CMS_RS_SCLLOW,
		I2CMS_RS_SDAHI,
		I2CMS_RS_SCLREL,
		I2CMS_RS_BOTHHI,
		I2CMS_RS_SDALO,
		I2CMS_TX_LOW,
		I2CMS_TX_REL,
		I2CMS_TX_HIGH
	} i2cms_state_t;

endpackage

// file: i2cms_master.sv
// Purpose: Master-side sequencer for a two-wire serial bus
// Assumes: Open-drain pins resolved outside; lines sampled on mclk
// Notes:   Master receive, acknowledge send and stop generation not built
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "i2cms_cfg.svh"
`default_nettype none

module i2cms_master (
	input  wire logic       mclk,     // System clock, 10 MHz
	input  wire logic       rst_b,    // Synchronous reset, active low
	input  wire logic [2:0] addr,     // Register index
	input  wire logic [7:0] wdata,    // Write data
	input  wire logic       wr,       // Write strobe
	input  wire logic       rd,       // Read strobe
	output logic      [7:0] rdata,    // Read data, cycle after rd
	input  wire logic       scl_in,   // Clock line level
	output logic            scl_out,  // Clock line drive value, always low
	output logic            scl_oe,   // Clock line pulled low when high
	input  wire logic       sda_in,   // Data line level
	output logic            sda_out,  // Data line drive value, always low
	output logic            sda_oe    // Data line pulled low when high
);

	i2cms_pkg::i2cms_state_t state_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] rate_reg;
	logic [7:0] txbuf_reg;
	logic [7:0] shift_reg;
	logic [3:0] bit_reg;
	logic [7:0] brg_reg;
	logic       start_req_reg;
	logic       rstart_req_reg;
	logic       stop_req_reg;
	logic       ack_res_reg;
	logic       event_reg;
	logic       write_collision_flag_reg;
	logic       bcol_reg;
	logic       sdet_reg;
	logic       pdet_reg;
	logic       loaded_reg;
	logic       scl_oe_reg;
	logic       sda_oe_reg;
	logic [7:0] rdata_reg;
	logic       scl_m_reg, scl_s_reg, scl_p_reg;
	logic       sda_m_reg, sda_s_reg, sda_p_reg;

	// Decode of the register port
	wire        enable   = ctrl_reg[`I2CMS_CTRL_EN];
	wire [2:0]  mode     = ctrl_reg[`I2CMS_CTRL_MODE_HI:`I2CMS_CTRL_MODE_LO];
	wire        hw_mode  = enable && (mode == `I2CMS_MODE_HWMASTER);
	wire        fw_mode  = enable && (mode == `I2CMS_MODE_FWMASTER);
	wire        wr_ctrl  = wr && (addr == `I2CMS_OFS_CTRL);
	wire        wr_busc  = wr && (addr == `I2CMS_OFS_BUSCTL);
	wire        wr_stat  = wr && (addr == `I2CMS_OFS_STATUS);
	wire        wr_rate  = wr && (addr == `I2CMS_OFS_RATE);
	wire        wr_txbuf = wr && (addr == `I2CMS_OFS_TXBUF);
	wire        idle     = (state_reg == i2cms_pkg::I2CMS_IDLE);
	wire        busy     = !idle || start_req_reg || rstart_req_reg;
	wire        brg_to   = (brg_reg == 8'h00);
	wire        last_bit = (bit_reg == `I2CMS_LAST_BIT);

	// Own start suspends detection; restart states keep it
	wire        own_start = (state_reg == i2cms_pkg::I2CMS_ST_WAIT) ||
	                        (state_reg == i2cms_pkg::I2CMS_ST_HOLD);
	wire        in_rs = (state_reg == i2cms_pkg::I2CMS_RS_SCLLOW) ||
	                    (state_reg == i2cms_pkg::I2CMS_RS_SDAHI) ||
	                    (state_reg == i2cms_pkg::I2CMS_RS_SCLREL) ||
	                    (state_reg == i2cms_pkg::I2CMS_RS_BOTHHI) ||
	                    (state_reg == i2cms_pkg::I2CMS_RS_SDALO);
	// Condition detection on synchronised levels only
	wire        start_seen = scl_s_reg && scl_p_reg && sda_p_reg && !sda_s_reg;
	wire        stop_seen  = scl_s_reg && scl_p_reg && !sda_p_reg && sda_s_reg;
	wire        det_on     = (hw_mode && !own_start) || fw_mode;

	// Two-stage synchronisers, then one delayed copy for edges
	always_ff @(posedge mclk) begin
		scl_m_reg <= scl_in;
		scl_s_reg <= scl_m_reg;
		scl_p_reg <= scl_s_reg;
		sda_m_reg <= sda_in;
		sda_s_reg <= sda_m_reg;
		sda_p_reg <= sda_s_reg;
	end

	// Control and rate registers
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ctrl_reg <= `I2CMS_RST_CTRL;
			rate_reg <= `I2CMS_RST_RATE;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= wdata;
			if (wr_rate)
				rate_reg <= wdata;
		end
	end

	// Read port, answer one cycle after the strobe
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rdata_reg <= 8'h00;
		end else if (rd) begin
			case (addr)
				`I2CMS_OFS_CTRL:   rdata_reg <= ctrl_reg;
				`I2CMS_OFS_BUSCTL: rdata_reg <= {1'b0, ack_res_reg, 3'h0, stop_req_reg,
				                                 rstart_req_reg, start_req_reg};
				`I2CMS_OFS_STATUS: rdata_reg <= {2'h0, loaded_reg, pdet_reg, sdet_reg,
				                                 bcol_reg, write_collision_flag_reg, event_reg};
				`I2CMS_OFS_RATE:   rdata_reg <= rate_reg;
				`I2CMS_OFS_TXBUF:  rdata_reg <= txbuf_reg;
				default:           rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// Sequencer, counter and flags; later set assignments win over clears
	always_ff @(posedge mclk) begin
		if (!rst_b || !enable) begin
			state_reg      <= i2cms_pkg::I2CMS_IDLE;
			start_req_reg  <= 1'b0;
			rstart_req_reg <= 1'b0;
			stop_req_reg   <= 1'b0;
			sdet_reg       <= 1'b0;
			pdet_reg       <= 1'b0;
			scl_oe_reg     <= 1'b0;
			sda_oe_reg     <= 1'b0;
			loaded_reg     <= 1'b0;
			brg_reg        <= 8'h00;
			bit_reg        <= 4'h0;
			shift_reg      <= 8'h00;
			if (!rst_b) begin
				txbuf_reg   <= 8'h00;
				ack_res_reg <= 1'b0;
				event_reg   <= 1'b0;
				write_collision_flag_reg    <= 1'b0;
				bcol_reg    <= 1'b0;
			end else if (wr_stat) begin
				event_reg <= event_reg & ~wdata[`I2CMS_ST_EVENT];
				write_collision_flag_reg  <= write_collision_flag_reg  & ~wdata[`I2CMS_ST_WRITE_COLLISION_FLAG];
				bcol_reg  <= bcol_reg  & ~wdata[`I2CMS_ST_BCOL];
			end
		end else begin
			// Software clears first, hardware sets below override
			if (wr_stat) begin
				event_reg <= event_reg & ~wdata[`I2CMS_ST_EVENT];
				write_collision_flag_reg  <= write_collision_flag_reg  & ~wdata[`I2CMS_ST_WRITE_COLLISION_FLAG];
				bcol_reg  <= bcol_reg  & ~wdata[`I2CMS_ST_BCOL];
				sdet_reg  <= sdet_reg  & ~wdata[`I2CMS_ST_SDET];
				pdet_reg  <= pdet_reg  & ~wdata[`I2CMS_ST_PDET];
			end
			// Default counter behaviour: count down, hold at zero
			if (!brg_to)
				brg_reg <= brg_reg - 8'h01;

			// Bus control writes; locked while a start is pending
			if (wr_busc && hw_mode && !start_req_reg) begin
				if (idle && !rstart_req_reg) begin
					start_req_reg  <= wdata[`I2CMS_BC_START];
					rstart_req_reg <= wdata[`I2CMS_BC_RSTART] && !wdata[`I2CMS_BC_START];
				end
				stop_req_reg <= wdata[`I2CMS_BC_STOP];
			end

			// Condition detector
			if (det_on && start_seen) begin
				sdet_reg <= 1'b1;
				pdet_reg <= 1'b0;
				if (!in_rs)
					event_reg <= 1'b1;
			end
			if (det_on && stop_seen) begin
				pdet_reg  <= 1'b1;
				sdet_reg  <= 1'b0;
				event_reg <= 1'b1;
			end

			// Transmit buffer write: accepted only when nothing is pending
			if (wr_txbuf && hw_mode) begin
				if (busy) begin
					write_collision_flag_reg <= 1'b1;
				end else begin
					txbuf_reg  <= wdata;
					shift_reg  <= wdata;
					loaded_reg <= 1'b1;
					bit_reg    <= 4'h0;
					scl_oe_reg <= 1'b1;
					brg_reg    <= rate_reg;
					state_reg  <= i2cms_pkg::I2CMS_TX_LOW;
				end
			end

			// Firmware mode pins straight from control bits
			if (fw_mode) begin
				scl_oe_reg <= ctrl_reg[`I2CMS_CTRL_FW_SCL];
				sda_oe_reg <= ctrl_reg[`I2CMS_CTRL_FW_SDA];
			end

			case (state_reg)
				i2cms_pkg::I2CMS_IDLE: begin
					if (hw_mode && start_req_reg) begin
						if (!scl_s_reg && !sda_s_reg) begin
							bcol_reg      <= 1'b1;
							start_req_reg <= 1'b0;
						end else if (scl_s_reg && sda_s_reg) begin
							brg_reg   <= rate_reg;
							state_reg <= i2cms_pkg::I2CMS_ST_WAIT;
						end
					end else if (hw_mode && rstart_req_reg) begin
						scl_oe_reg <= 1'b1;
						state_reg  <= i2cms_pkg::I2CMS_RS_SCLLOW;
					end
				end
				i2cms_pkg::I2CMS_ST_WAIT: begin
					if (!scl_s_reg) begin
						bcol_reg      <= 1'b1;
						start_req_reg <= 1'b0;
						state_reg     <= i2cms_pkg::I2CMS_IDLE;
					end else if (brg_to) begin
						if (sda_s_reg) begin
							sda_oe_reg <= 1'b1;
							sdet_reg   <= 1'b1;
							pdet_reg   <= 1'b0;
							brg_reg    <= rate_reg;
							state_reg  <= i2cms_pkg::I2CMS_ST_HOLD;
						end else begin
							bcol_reg      <= 1'b1;
							start_req_reg <= 1'b0;
							state_reg     <= i2cms_pkg::I2CMS_IDLE;
						end
					end
				end
				i2cms_pkg::I2CMS_ST_HOLD: begin
					if (brg_to) begin
						start_req_reg <= 1'b0;
						event_reg     <= 1'b1;
						state_reg     <= i2cms_pkg::I2CMS_IDLE;
					end
				end
				i2cms_pkg::I2CMS_RS_SCLLOW: begin
					// Count only once the low is really on the wire
					if (!scl_s_reg) begin
						sda_oe_reg <= 1'b0;
						brg_reg    <= rate_reg;
						state_reg  <= i2cms_pkg::I2CMS_RS_SDAHI;
					end
				end
				i2cms_pkg::I2CMS_RS_SDAHI: begin
					if (brg_to && sda_s_reg) begin
						scl_oe_reg <= 1'b0;
						state_reg  <= i2cms_pkg::I2CMS_RS_SCLREL;
					end
				end
				i2cms_pkg::I2CMS_RS_SCLREL: begin
					if (scl_s_reg) begin
						if (!sda_s_reg) begin
							bcol_reg       <= 1'b1;
							rstart_req_reg <= 1'b0;
							state_reg      <= i2cms_pkg::I2CMS_IDLE;
						end else begin
							brg_reg   <= rate_reg;
							state_reg <= i2cms_pkg::I2CMS_RS_BOTHHI;
						end
					end
				end
				i2cms_pkg::I2CMS_RS_BOTHHI: begin
					if (!scl_s_reg) begin
						bcol_reg       <= 1'b1;
						rstart_req_reg <= 1'b0;
						state_reg      <= i2cms_pkg::I2CMS_IDLE;
					end else if (brg_to) begin
						sda_oe_reg <= 1'b1;
						brg_reg    <= rate_reg;
						state_reg  <= i2cms_pkg::I2CMS_RS_SDALO;
					end
				end
				i2cms_pkg::I2CMS_RS_SDALO: begin
					if (brg_to) begin
						scl_oe_reg     <= 1'b1;
						rstart_req_reg <= 1'b0;
						event_reg      <= 1'b1;
						state_reg      <= i2cms_pkg::I2CMS_IDLE;
					end
				end
				i2cms_pkg::I2CMS_TX_LOW: begin
					// Data moves one cycle after the fall, held all phase
					sda_oe_reg <= !last_bit && !shift_reg[7];
					if (brg_to) begin
						scl_oe_reg <= 1'b0;
						state_reg  <= i2cms_pkg::I2CMS_TX_REL;
					end
				end
				i2cms_pkg::I2CMS_TX_REL: begin
					// Counter frozen while a slave stretches the clock
					if (scl_s_reg) begin
						brg_reg   <= rate_reg;
						state_reg <= i2cms_pkg::I2CMS_TX_HIGH;
						if (last_bit)
							ack_res_reg <= sda_s_reg;
					end
				end
				i2cms_pkg::I2CMS_TX_HIGH: begin
					if (brg_to) begin
						scl_oe_reg <= 1'b1;
						if (last_bit) begin
							event_reg <= 1'b1;
							state_reg <= i2cms_pkg::I2CMS_IDLE;
						end else begin
							if (bit_reg == 4'h7) begin
								loaded_reg <= 1'b0;
							end
							bit_reg   <= bit_reg + 4'h1;
							shift_reg <= {shift_reg[6:0], 1'b0};
							brg_reg   <= rate_reg;
							state_reg <= i2cms_pkg::I2CMS_TX_LOW;
						end
					end
				end
				default: begin
					state_reg <= i2cms_pkg::I2CMS_IDLE;
				end
			endcase

			// Collision release: let go of both lines
			if ((state_reg == i2cms_pkg::I2CMS_RS_SCLREL && scl_s_reg && !sda_s_reg) ||
			    (state_reg == i2cms_pkg::I2CMS_RS_BOTHHI && !scl_s_reg)) begin
				scl_oe_reg <= 1'b0;
				sda_oe_reg <= 1'b0;
			end
		end
	end

	// Outputs from flip-flops; drive value is always low
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end

	assign rdata  = rdata_reg;
	assign scl_oe = scl_oe_reg;
	assign sda_oe = sda_oe_reg;

endmodule

`default_nettype wire

// file: i2cms_master_sva.sv
// Purpose: Port assertions for the bus sequencer
// Assumes: Reload value kept at 2 or more, so one period is 3 cycles or more
// Notes:   Bound onto i2cms_master
`timescale 1ns/1ps
`default_nettype none
module i2cms_master_sva (
	input wire logic       mclk,    // Clock
	input wire logic       rst_b,   // Reset
	input wire logic [2:0] addr,    // Index
	input wire logic [7:0] wdata,   // Write data
	input wire logic       wr,      // Write
	input wire logic       rd,      // Read
	input wire logic [7:0] rdata,   // Read data
	input wire logic       scl_in,  // Clock line
	input wire logic       scl_out, // Clock value
	input wire logic       scl_oe,  // Clock pull
	input wire logic       sda_in,  // Data line
	input wire logic       sda_out, // Data value
	input wire logic       sda_oe   // Data pull
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	// Open drain: a one is never driven
	property p_drive_low;
		scl_out == 1'b0 && sda_out == 1'b0;
	endproperty
	a_drive_low: assert property (p_drive_low)
		else $error("bus pin driven high");
	// Reset must win even mid-transfer, so it is not disabled here
	property p_reset;
		disable iff (1'b0) !rst_b |=> !scl_oe && !sda_oe && rdata == 8'h00;
	endproperty
	a_reset: assert property (p_reset)
		else $error("pins not released by reset");
	// Start data low lasts a full period with the clock free
	property p_start_hold;
		$rose(sda_oe) && !scl_oe |-> sda_oe [*3];
	endproperty
	a_start_hold: assert property (p_start_hold)
		else $error("start too short");
	property p_start_lines;
		$rose(sda_oe) && !scl_oe |-> $past(scl_in) && $past(sda_in);
	endproperty
	a_start_lines: assert property (p_start_lines)
		else $error("start on a busy bus");
	// Data released only while the clock is held low
	property p_sda_fall;
		$fell(sda_oe) |-> scl_oe && $past(scl_oe);
	endproperty
	a_sda_fall: assert property (p_sda_fall)
		else $error("data released with clock high");
	property p_low_phase;
		$rose(scl_oe) |-> scl_oe [*3];
	endproperty
	a_low_phase: assert property (p_low_phase)
		else $error("clock low too short");
	property p_high_phase;
		$fell(scl_oe) |-> !scl_oe [*3];
	endproperty
	a_high_phase: assert property (p_high_phase)
		else $error("clock high too short");
	// A stretched clock halts the period count
	property p_stretch;
		!scl_oe && !scl_in |=> !scl_oe [*3];
	endproperty
	a_stretch: assert property (p_stretch)
		else $error("stretch not honoured");
	c_start: cover property ($rose(sda_oe) && !scl_oe);
	c_stretch: cover property (!scl_oe && !scl_in);
	c_load: cover property (wr && addr == 3'h4);
endmodule
bind i2cms_master i2cms_master_sva i2cms_master_sva_i (.mclk(mclk), .rst_b(rst_b), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl_in), .scl_out(scl_out),
	.scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// file: i2cms_slave_model.sv
// Purpose: Behavioural slave on the two-wire bus, no address match
// Assumes: Lines resolved with pull-ups outside
// Notes:   Stretch holds the clock 1.5 us after each fall
`timescale 1ns/1ps
`default_nettype none
module i2cms_slave_model (
	input  wire logic       scl,       // Clock line
	input  wire logic       sda,       // Data line
	input  wire logic       nack,      // Leave ack slot free
	input  wire logic       stretch,   // Stretch each low phase
	input  wire logic       hold_sda,  // Jam data low
	output logic            scl_pull,  // Pulls clock low
	output logic            sda_pull,  // Pulls data low
	output logic      [7:0] last_byte  // Last byte seen
);
	int         cnt;
	logic [7:0] sh;
	logic       ack_pull;
	initial begin
		cnt = 0;
		sh = 8'h00;
		ack_pull = 1'b0;
		scl_pull = 1'b0;
		last_byte = 8'h00;
	end
	assign sda_pull = hold_sda | ack_pull;
	// Start seen: data falls while the clock is high
	always @(negedge sda) if (scl) cnt = 0;
	// Shift in on the rising clock, first bit first
	always @(posedge scl) begin
		if (cnt < 8) sh = {sh[6:0], sda};
		cnt = cnt + 1;
		if (cnt == 8) last_byte = sh;
	end
	always @(negedge scl) begin
		ack_pull = (cnt == 8) && !nack;
		if (cnt == 9) cnt = 0;
		if (stretch) begin
			scl_pull = 1'b1;
			#1500 scl_pull = 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: i2c_master_sequencer_bench.sv
// Purpose: Self-checking bench for the bus sequencer
// Assumes: Pull-ups on both lines, slave model on the far side
// Notes:   Reload value kept at 2..5 so the checker bounds hold
`timescale 1ns/1ps
`default_nettype none
module i2c_master_sequencer_bench;
	logic       mclk, rst_b, wr, rd, nack, stretch, hold_sda;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, got, b, last_byte;
	logic       scl_out, scl_oe, sda_out, sda_oe, scl_pull, sda_pull;
	wire        scl_w, sda_w;
	int         bad_count, compares, seed, i, n;

	// Pull-ups: a line is low only while someone pulls it
	assign scl_w = !(scl_oe === 1'b1 || scl_pull);
	assign sda_w = !(sda_oe === 1'b1 || sda_pull);
	i2cms_master i2cms_master_i (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
	i2cms_slave_model i2cms_slave_model_i (.scl(scl_w), .sda(sda_w), .nack(nack),
		.stretch(stretch), .hold_sda(hold_sda), .scl_pull(scl_pull), .sda_pull(sda_pull),
		.last_byte(last_byte));
	initial mclk = 1'b0;
	always #50 mclk = ~mclk;

	function automatic logic [7:0] st(input logic ev, input logic wc, input logic bc);
		return {5'h00, bc, wc, ev};
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rreg(input logic [2:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		got = rdata;
	endtask
	task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		rreg(a);
		chk(got & m, e);
	endtask
	// Poll the event flag, bounded; running out counts as a mismatch
	task automatic wait_ev;
		n = 0;
		do begin
			rreg(3'h2);
			n++;
		end while (got[0] !== 1'b1 && n < 600);
		if (got[0] !== 1'b1) begin
			bad_count++;
			$display("ERROR %0t event flag never set", $time);
		end
	endtask
	task automatic give_verdict;
		$display("bad_count %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#4000000;
		bad_count++;
		give_verdict;
	end

	initial begin
		seed = 26325;
		{rst_b, wr, rd, nack, stretch, hold_sda} = 6'h00;
		addr = 3'h0;
		wdata = 8'h00;
		bad_count = 0;
		compares = 0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		rchk(3'h0, 8'hff, 8'h00);
		rchk(3'h3, 8'hff, 8'h04);
		wreg(3'h7, 8'h5a);
		rchk(3'h7, 8'hff, 8'h00);
		// Start with a colliding buffer write and a locked-out restart behind it
		wreg(3'h3, 8'h02);
		wreg(3'h0, 8'h01);
		wreg(3'h1, 8'h01);
		wreg(3'h4, 8'h99);
		wreg(3'h1, 8'h02);
		wait_ev;
		chk(got & 8'h3f, st(1'b1, 1'b1, 1'b0) | 8'h08);
		chk({6'h00, scl_oe, sda_oe}, 8'h01);
		rchk(3'h1, 8'h07, 8'h00);
		rchk(3'h4, 8'hff, 8'h00);
		wreg(3'h2, 8'h1f);
		// Random bytes, rates and acks, stretching on odd passes; restart before the last
		for (i = 0; i < 5; i++) begin
			b = 8'($random(seed));
			nack = 1'($random(seed));
			stretch = i[0];
			wreg(3'h3, {6'h00, b[7:6]} + 8'h02);
			if (i == 0) b[0] = 1'b0;
			if (i == 4) begin
				wreg(3'h1, 8'h02);
				wait_ev;
				chk(got & 8'h0f, 8'h09);
				chk({6'h00, scl_oe, sda_oe}, 8'h03);
				wreg(3'h2, 8'h1f);
				b[0] = 1'b1;
			end
			wreg(3'h4, b);
			rchk(3'h2, 8'h20, 8'h20);
			wreg(3'h4, ~b);
			wreg(3'h1, 8'h02);
			wait_ev;
			chk(got & 8'h27, st(1'b1, 1'b1, 1'b0));
			chk(last_byte, b);
			rchk(3'h1, 8'h42, nack ? 8'h40 : 8'h00);
			rchk(3'h4, 8'hff, b);
			chk({6'h00, scl_oe, sda_oe}, 8'h02);
			wreg(3'h2, 8'h1f);
		end
		// Firmware mode: detector and direct pin pulls only
		wreg(3'h0, 8'h00);
		wreg(3'h0, 8'h03);
		wreg(3'h2, 8'h1f);
		hold_sda = 1'b1;
		repeat (10) @(posedge mclk);
		hold_sda = 1'b0;
		repeat (10) @(posedge mclk);
		wreg(3'h0, 8'h33);
		repeat (4) @(posedge mclk);
		chk({6'h00, scl_oe, sda_oe}, 8'h03);
		wreg(3'h0, 8'h13);
		wreg(3'h4, 8'h3c);
		repeat (4) @(posedge mclk);
		wreg(3'h0, 8'h03);
		rchk(3'h2, 8'h1b, 8'h11);
		wreg(3'h0, 8'h00);
		rchk(3'h2, 8'h18, 8'h00);
		// Data jammed low while the start waits
		wreg(3'h0, 8'h01);
		wreg(3'h3, 8'h05);
		wreg(3'h1, 8'h01);
		hold_sda = 1'b1;
		repeat (20) @(posedge mclk);
		rchk(3'h2, 8'h06, 8'h04);
		rchk(3'h1, 8'h01, 8'h00);
		hold_sda = 1'b0;
		// Restart on a clean bus, then jam data as the clock is let go
		wreg(3'h2, 8'h1f);
		wreg(3'h1, 8'h02);
		@(negedge scl_oe);
		hold_sda = 1'b1;
		repeat (20) @(posedge mclk);
		hold_sda = 1'b0;
		rchk(3'h2, 8'h06, 8'h04);
		rchk(3'h1, 8'h02, 8'h00);
		// Idle load, then reset in the middle of the byte
		wreg(3'h4, 8'hc3);
		repeat (30) @(posedge mclk);
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		@(negedge mclk);
		chk({6'h00, scl_oe, sda_oe}, 8'h00);
		rchk(3'h0, 8'hff, 8'h00);
		rchk(3'h2, 8'hff, 8'h00);
		give_verdict;
	end
endmodule
`default_nettype wire
